// ==== pkg/avc_pkg.sv ====
package avc_pkg;

	// Cycle counter layout
	localparam int CNT_W = 14;
	localparam int DEC_W = 6;
	localparam int SETTLE_BIT = 13;
	localparam logic [DEC_W-1:0] CONV_LAST = 6'h3f;
	localparam logic [DEC_W-1:0] RDY_LEAD = 6'h3e;
	localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;

	// Data path widths
	localparam int RAW_W = 18;
	localparam int WORD_W = 16;
	localparam int GAIN_W = 16;
	localparam int GAIN_FRAC = 14;
	localparam int PROD_W = RAW_W + GAIN_W + 2;
	localparam int SCL_W = PROD_W - GAIN_FRAC;
	localparam int ACC_W = RAW_W + 3;
	localparam int SPAN_W = RAW_W + 1;
	localparam int REM_W = SPAN_W + 1;
	localparam int NUM_W = 30;

	// Values after reset
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h4000;
	localparam logic [RAW_W-1:0] OFS_RST = 18'h00000;
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	// Averaging and gain computation
	localparam logic [2:0] AVG_LAST = 3'h7;
	localparam logic [NUM_W-1:0] CODE_SPAN = 30'h3fffc000;
	localparam logic [4:0] DIV_STEPS = 5'h1e;

	// Output range limits in scaled form
	localparam logic signed [SCL_W-1:0] BIP_MAX = 22'sh007fff;
	localparam logic signed [SCL_W-1:0] BIP_MIN = 22'sh3f8000;
	localparam logic signed [SCL_W-1:0] UNI_MAX = 22'sh00ffff;
	localparam logic signed [SCL_W-1:0] UNI_MIN = 22'sh000000;

	typedef enum logic [4:0] {
		CS_IDLE = 5'h01,
		CS_ALIGN = 5'h02,
		CS_SETTLE = 5'h04,
		CS_AVG = 5'h08,
		CS_CALC = 5'h10
	} avc_cal_state_t;

	typedef enum logic [1:0] {
		IN_PINS = 2'h0,
		IN_GND = 2'h1,
		IN_POS = 2'h2,
		IN_NEG = 2'h3
	} avc_in_sel_t;

	// Full-scale code for the given direction and input mode
	function automatic logic [WORD_W-1:0] full_scale(input logic neg, input logic bip);
		if (bip) begin
			full_scale = neg ? 16'h8000 : 16'h7fff;
		end else begin
			full_scale = neg ? 16'h0000 : 16'hffff;
		end
	endfunction

endpackage

// ==== pkg/avc_cor_if.sv ====
interface avc_cor_if;
	import avc_pkg::*;
	logic signed [RAW_W-1:0] raw;
	logic signed [RAW_W-1:0] offset;
	logic [GAIN_W-1:0] gain;
	logic bipolar;
	logic load;
	logic clip;
	logic clip_neg;
	logic oor;
	logic [WORD_W-1:0] word;

	modport seq (
		output raw, offset, gain, bipolar, load, clip, clip_neg,
		input oor, word
	);
	modport cor (
		input raw, offset, gain, bipolar, load, clip, clip_neg,
		output oor, word
	);
endinterface

// ==== hdl/avc_cycle_cnt.sv ====
module avc_cycle_cnt import avc_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control
	input wire logic clr_i,
	// Status
	output logic [CNT_W-1:0] cnt_o,
	output logic conv_done_o,
	output logic settle_o
);

	logic [CNT_W-1:0] cnt_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= CNT_RST;
		end else if (clr_i) begin
			cnt_ff <= CNT_RST;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign cnt_o = cnt_ff;
	assign conv_done_o = cnt_ff[DEC_W-1:0] == CONV_LAST;
	assign settle_o = cnt_ff[SETTLE_BIT];

endmodule // avc_cycle_cnt

// ==== hdl/avc_corrector.sv ====
module avc_corrector import avc_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Correction channel
	avc_cor_if.cor cor
);

	logic signed [SPAN_W-1:0] diff;
	logic signed [PROD_W-1:0] prod;
	logic signed [SCL_W-1:0] scaled;
	logic over_hi;
	logic over_lo;
	logic [WORD_W-1:0] word_ff;

	assign diff = {cor.raw[RAW_W-1], cor.raw} - {cor.offset[RAW_W-1], cor.offset};
	assign prod = diff * $signed({1'b0, cor.gain});
	assign scaled = prod[PROD_W-1:GAIN_FRAC];
	assign over_hi = cor.bipolar ? (scaled > BIP_MAX) : (scaled > UNI_MAX);
	assign over_lo = cor.bipolar ? (scaled < BIP_MIN) : (scaled < UNI_MIN);
	assign cor.oor = over_hi | over_lo;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_ff <= WORD_RST;
		end else if (cor.load) begin
			if (cor.clip) begin
				word_ff <= full_scale(cor.clip_neg, cor.bipolar);
			end else if (over_hi) begin
				word_ff <= full_scale(1'b0, cor.bipolar);
			end else if (over_lo) begin
				word_ff <= full_scale(1'b1, cor.bipolar);
			end else begin
				word_ff <= scaled[WORD_W-1:0];
			end
		end
	end

	assign cor.word = word_ff;

endmodule // avc_corrector

// ==== hdl/avc_seq.sv ====
module avc_seq import avc_pkg::*; (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Control inputs
	input wire logic reset_pin_i,
	input wire logic sync_i,
	input wire logic cal_i,
	input wire logic bipolar_i,
	// Filter and modulator status
	input wire logic filt1_ovf_i,
	input wire logic filt1_ovf_neg_i,
	input wire logic signed [RAW_W-1:0] filt2_result_i,
	input wire logic mod_unstable_i,
	input wire logic mod_unstable_neg_i,
	// Parallel port
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	output logic [WORD_W-1:0] data_o,
	output logic data_oe_n_o,
	output logic word_ready_n_o,
	// Serial validity
	output logic data_valid_flag_o,
	// Modulator and filter control
	output logic mod_reset_o,
	output logic [1:0] mod_in_sel_o,
	output logic mod_half_ref_o,
	output logic filter_reset_o,
	output logic cal_busy_o
);

	avc_cor_if cor_bus();

	logic [CNT_W-1:0] cnt;
	logic conv_done;
	logic settle;
	logic cnt_clr;

	logic sync_ff;
	logic rstp_ff;
	logic sync_rise;
	logic rstp_rise;
	logic abort;
	logic filt_hold;

	avc_cal_state_t cal_st_ff;
	avc_in_sel_t phase_ff;
	avc_in_sel_t nxt_phase;
	logic bip_cal_ff;
	logic cal_idle;
	logic more_steps;
	logic step_start;
	logic cal_done;
	logic calc_first_ff;

	logic [2:0] avg_cnt_ff;
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [ACC_W-1:0] nxt_acc;
	logic signed [RAW_W-1:0] avg_zero_ff;
	logic signed [RAW_W-1:0] avg_pos_ff;
	logic signed [RAW_W-1:0] avg_neg_ff;

	logic signed [SPAN_W-1:0] span;
	logic [SPAN_W-1:0] den_ff;
	logic [REM_W-1:0] rem_ff;
	logic [REM_W-1:0] rem_sh;
	logic [NUM_W-1:0] num_ff;
	logic [4:0] div_cnt_ff;
	logic [GAIN_W-1:0] gain_new;

	logic signed [RAW_W-1:0] ofs_ff;
	logic [GAIN_W-1:0] gain_ff;

	logic ovf1_seen_ff;
	logic ovf1_neg_ff;
	logic ovf1_now;
	logic bad_ff;
	logic settled_ff;
	logic dvf_ff;
	logic nxt_dvf;
	logic mod_reset_ff;
	logic filt_reset_ff;

	avc_cycle_cnt u_cnt (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.clr_i(cnt_clr),
		.cnt_o(cnt),
		.conv_done_o(conv_done),
		.settle_o(settle)
	);

	avc_corrector u_cor (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.cor(cor_bus)
	);

	// Edge detection on sync and reset inputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync_ff <= 1'b0;
			rstp_ff <= 1'b0;
		end else begin
			sync_ff <= sync_i;
			rstp_ff <= reset_pin_i;
		end
	end

	assign sync_rise = sync_i & ~sync_ff;
	assign rstp_rise = reset_pin_i & ~rstp_ff;
	assign abort = sync_rise | rstp_rise;
	assign filt_hold = sync_i | reset_pin_i;

	assign cal_idle = cal_st_ff == CS_IDLE;
	assign more_steps = (phase_ff == IN_GND) | ((phase_ff == IN_POS) & bip_cal_ff);
	assign nxt_phase = (phase_ff == IN_GND) ? IN_POS : IN_NEG;
	assign step_start = ((cal_st_ff == CS_ALIGN) & conv_done) |
		((cal_st_ff == CS_CALC) & calc_first_ff & more_steps);
	assign cal_done = (cal_st_ff == CS_CALC) & ~calc_first_ff & (div_cnt_ff == 5'h00);
	assign cnt_clr = filt_hold | mod_unstable_i | step_start | cal_done;

	// Calibration sequencer
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cal_st_ff <= CS_IDLE;
			phase_ff <= IN_PINS;
			bip_cal_ff <= 1'b0;
		end else if (abort || filt_hold) begin
			cal_st_ff <= CS_IDLE;
			phase_ff <= IN_PINS;
		end else begin
			case (cal_st_ff)
				CS_IDLE: begin
					if (cal_i) begin
						cal_st_ff <= CS_ALIGN;
						bip_cal_ff <= bipolar_i;
					end
				end
				CS_ALIGN: begin
					if (conv_done) begin
						cal_st_ff <= CS_SETTLE;
						phase_ff <= IN_GND;
					end
				end
				CS_SETTLE: begin
					if (settle) begin
						cal_st_ff <= CS_AVG;
					end
				end
				CS_AVG: begin
					if (conv_done && avg_cnt_ff == AVG_LAST) begin
						cal_st_ff <= CS_CALC;
					end
				end
				CS_CALC: begin
					if (calc_first_ff) begin
						if (more_steps) begin
							cal_st_ff <= CS_SETTLE;
							phase_ff <= nxt_phase;
						end
					end else if (div_cnt_ff == 5'h00) begin
						cal_st_ff <= CS_IDLE;
						phase_ff <= IN_PINS;
					end
				end
				default: begin
					cal_st_ff <= CS_IDLE;
				end
			endcase
		end
	end

	// Averaging of eight results per measurement step
	assign nxt_acc = acc_ff + ACC_W'(filt2_result_i);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_ff <= '0;
			avg_cnt_ff <= 3'h0;
			avg_zero_ff <= OFS_RST;
			avg_pos_ff <= OFS_RST;
			avg_neg_ff <= OFS_RST;
			calc_first_ff <= 1'b0;
		end else begin
			calc_first_ff <= 1'b0;
			if (cal_st_ff != CS_AVG) begin
				acc_ff <= '0;
				avg_cnt_ff <= 3'h0;
			end else if (conv_done && !abort && !filt_hold) begin
				acc_ff <= nxt_acc;
				avg_cnt_ff <= avg_cnt_ff + 1'b1;
				if (avg_cnt_ff == AVG_LAST) begin
					calc_first_ff <= 1'b1;
					if (phase_ff == IN_GND) begin
						avg_zero_ff <= nxt_acc[ACC_W-1:3];
					end else if (phase_ff == IN_POS) begin
						avg_pos_ff <= nxt_acc[ACC_W-1:3];
					end else begin
						avg_neg_ff <= nxt_acc[ACC_W-1:3];
					end
				end
			end
		end
	end

	// Gain factor: full code span divided by measured span
	assign span = bip_cal_ff ? (SPAN_W'(avg_pos_ff) - SPAN_W'(avg_neg_ff)) :
		(SPAN_W'(avg_pos_ff) - SPAN_W'(avg_zero_ff));
	assign rem_sh = {rem_ff[REM_W-2:0], num_ff[NUM_W-1]};
	assign gain_new = (|num_ff[NUM_W-1:GAIN_W]) ? 16'hffff : num_ff[GAIN_W-1:0];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			den_ff <= '0;
			rem_ff <= '0;
			num_ff <= '0;
			div_cnt_ff <= 5'h00;
		end else if (cal_st_ff == CS_CALC && calc_first_ff && !more_steps) begin
			den_ff <= span[SPAN_W-1] ? 19'h00001 : span;
			rem_ff <= '0;
			num_ff <= CODE_SPAN;
			div_cnt_ff <= DIV_STEPS;
		end else if (div_cnt_ff != 5'h00) begin
			div_cnt_ff <= div_cnt_ff - 1'b1;
			if (rem_sh >= {1'b0, den_ff}) begin
				rem_ff <= rem_sh - {1'b0, den_ff};
				num_ff <= {num_ff[NUM_W-2:0], 1'b1};
			end else begin
				rem_ff <= rem_sh;
				num_ff <= {num_ff[NUM_W-2:0], 1'b0};
			end
		end
	end

	// Calibration registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ofs_ff <= OFS_RST;
			gain_ff <= GAIN_UNITY;
		end else if (reset_pin_i) begin
			ofs_ff <= OFS_RST;
			gain_ff <= GAIN_UNITY;
		end else if (cal_done && !sync_i) begin
			ofs_ff <= bip_cal_ff ? avg_zero_ff : avg_zero_ff;
			gain_ff <= gain_new;
		end
	end

	// Overflow tracking; a new overflow wins over the period clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ovf1_seen_ff <= 1'b0;
			ovf1_neg_ff <= 1'b0;
		end else if (conv_done) begin
			ovf1_seen_ff <= filt1_ovf_i;
			ovf1_neg_ff <= filt1_ovf_neg_i;
		end else if (filt1_ovf_i) begin
			ovf1_seen_ff <= 1'b1;
			ovf1_neg_ff <= filt1_ovf_neg_i;
		end
	end

	assign ovf1_now = ovf1_seen_ff | filt1_ovf_i;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bad_ff <= 1'b0;
		end else if (conv_done && cal_idle && !filt_hold) begin
			bad_ff <= ovf1_now | cor_bus.oor;
		end
	end

	// Settling after power-up, sync, reset, calibration or instability
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			settled_ff <= 1'b0;
		end else if (cnt_clr || !cal_idle) begin
			settled_ff <= 1'b0;
		end else if (settle) begin
			settled_ff <= 1'b1;
		end
	end

	assign nxt_dvf = calc_first_ff | (settled_ff & ~bad_ff & cal_idle & ~cnt_clr);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dvf_ff <= 1'b0;
		end else begin
			dvf_ff <= nxt_dvf;
		end
	end

	// Modulator and filter control
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mod_reset_ff <= 1'b1;
			filt_reset_ff <= 1'b1;
		end else begin
			mod_reset_ff <= reset_pin_i | mod_unstable_i;
			filt_reset_ff <= filt_hold | mod_unstable_i;
		end
	end

	// Correction channel
	assign cor_bus.raw = filt2_result_i;
	assign cor_bus.offset = ofs_ff;
	assign cor_bus.gain = gain_ff;
	assign cor_bus.bipolar = bipolar_i;
	assign cor_bus.load = cal_idle & ~filt_hold & (conv_done | mod_unstable_i);
	assign cor_bus.clip = ovf1_now | mod_unstable_i;
	assign cor_bus.clip_neg = mod_unstable_i ? mod_unstable_neg_i :
		(filt1_ovf_i ? filt1_ovf_neg_i : ovf1_neg_ff);

	// Outputs
	assign data_o = cor_bus.word;
	assign data_oe_n_o = cs_n_i | rd_n_i;
	assign word_ready_n_o = ~settled_ff | ~cal_idle |
		(cnt[DEC_W-1:0] >= RDY_LEAD);
	assign data_valid_flag_o = dvf_ff;
	assign mod_reset_o = mod_reset_ff;
	assign mod_in_sel_o = phase_ff;
	assign mod_half_ref_o = bip_cal_ff & (phase_ff != IN_PINS);
	assign filter_reset_o = filt_reset_ff;
	assign cal_busy_o = ~cal_idle;

endmodule // avc_seq

// ==== bench/avc_seq_props.sv ====
module avc_seq_props import avc_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Inputs
	input wire logic reset_pin_i,
	input wire logic sync_i,
	input wire logic cal_i,
	input wire logic mod_unstable_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	// Outputs
	input wire logic data_oe_n_o,
	input wire logic word_ready_n_o,
	input wire logic data_valid_flag_o,
	input wire logic mod_reset_o,
	input wire logic filter_reset_o,
	input wire logic cal_busy_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	logic [CNT_W-1:0] quiet_ff;
	// Clocks since instability was last reported, saturating
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quiet_ff <= CNT_RST;
		end else if (mod_unstable_i) begin
			quiet_ff <= CNT_RST;
		end else if (quiet_ff != 14'h3fff) begin
			quiet_ff <= quiet_ff + 14'h0001;
		end
	end
	chk_oe_decode: assert property (data_oe_n_o == (cs_n_i | rd_n_i))
		else $error("output enable not decoded");
	chk_ready_lead: assert property ($fell(word_ready_n_o) |-> $past(word_ready_n_o, 2))
		else $error("ready_n high less than two clocks");
	chk_cal_start: assert property (!cal_busy_o && cal_i && !sync_i && !reset_pin_i |=> cal_busy_o)
		else $error("calibrate request not taken");
	chk_cal_marks: assert property ($rose(cal_busy_o) |=> (!data_valid_flag_o && word_ready_n_o)[*8])
		else $error("calibration start not marked invalid");
	chk_cal_pulse: assert property (cal_busy_o && $rose(data_valid_flag_o) |=> !data_valid_flag_o)
		else $error("calibration valid pulse too long");
	chk_abort_cal: assert property (($rose(sync_i) || $rose(reset_pin_i)) && cal_busy_o |=> !cal_busy_o)
		else $error("calibration not aborted");
	chk_mod_reset: assert property (reset_pin_i || mod_unstable_i |=> mod_reset_o)
		else $error("modulator not reset");
	chk_filter_hold: assert property (sync_i || reset_pin_i || mod_unstable_i |=> filter_reset_o)
		else $error("filter not held in reset");
	chk_unstable_low: assert property (mod_unstable_i |-> ##2 !data_valid_flag_o)
		else $error("valid high during instability");
	chk_settle_time: assert property (data_valid_flag_o |-> quiet_ff >= 14'h1fd6)
		else $error("valid before settling");
endmodule // avc_seq_props

// ==== bench/avc_host.sv ====
module avc_host import avc_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Converter side
	input wire logic en_i,
	input wire logic word_ready_n_i,
	input wire logic data_oe_n_i,
	input wire logic [WORD_W-1:0] data_i,
	// Host side
	output logic cs_n_o,
	output logic rd_n_o,
	output logic [WORD_W-1:0] word_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic rdy_q = 1'b1;
	logic [WORD_W-1:0] bus;
	assign cs_n_o = !en_i;
	assign rd_n_o = !en_i;
	// A released bus never shows the last word
	assign bus = data_oe_n_i ? ~word_o : data_i;
	// Take the old word as ready_n rises, before the new one lands
	always @(posedge clk_i) begin
		if (word_ready_n_i && !rdy_q) word_o <= bus;
		rdy_q <= word_ready_n_i;
	end
endmodule // avc_host

// ==== bench/tb_avc_seq.sv ====
module tb_avc_seq;
	timeunit 1ns;
	timeprecision 1ps;
	import avc_pkg::*;
	logic clk_i, rst_b_i, reset_pin_i, sync_i, cal_i, bipolar_i, cs_n_i, rd_n_i, host_en, v_q;
	logic filt1_ovf_i, filt1_ovf_neg_i, mod_unstable_i, mod_unstable_neg_i, data_oe_n_o;
	logic word_ready_n_o, data_valid_flag_o, mod_reset_o, mod_half_ref_o, filter_reset_o, cal_busy_o;
	logic signed [RAW_W-1:0] filt2_result_i, ana;
	logic [WORD_W-1:0] data_o, host_word;
	logic [1:0] mod_in_sel_o;
	int n_errors, comparisons, waited, pulses;
	// Control bits: valid, overflow, negative, bipolar
	logic [RAW_W-1:0] tv_in [7] = '{18'h08000, 18'h37fff, 18'h3fffb, 18'h00005, 18'h00005,
		18'h00005, 18'h00005};
	logic [3:0] tv_ctl [7] = '{4'h1, 4'h1, 4'h9, 4'h7, 4'h6, 4'h4, 4'h8};
	logic [WORD_W-1:0] tv_out [7] = '{16'h7fff, 16'h8000, 16'hfffb, 16'h8000, 16'h0000,
		16'hffff, 16'h0005};
	avc_seq i_dut (.clk_i, .rst_b_i, .reset_pin_i, .sync_i, .cal_i, .bipolar_i, .filt1_ovf_i,
		.filt1_ovf_neg_i, .filt2_result_i, .mod_unstable_i, .mod_unstable_neg_i, .cs_n_i,
		.rd_n_i, .data_o, .data_oe_n_o, .word_ready_n_o, .data_valid_flag_o, .mod_reset_o,
		.mod_in_sel_o, .mod_half_ref_o, .filter_reset_o, .cal_busy_o);
	avc_host i_host (.clk_i, .en_i(host_en), .word_ready_n_i(word_ready_n_o),
		.data_oe_n_i(data_oe_n_o), .data_i(data_o), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
		.word_o(host_word));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// Calibration sources follow the modulator input selector
	always @(negedge clk_i) begin
		case (mod_in_sel_o)
			2'h1: filt2_result_i <= 18'sh00100;
			2'h2: filt2_result_i <= 18'sh05655;
			2'h3: filt2_result_i <= 18'sh3ab00;
			default: filt2_result_i <= ana;
		endcase
	end
	always @(posedge clk_i) begin
		if (cal_busy_o && data_valid_flag_o && !v_q) pulses++;
		v_q <= data_valid_flag_o;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	function automatic logic probe(input int k);
		case (k)
			0: return data_valid_flag_o;
			1: return word_ready_n_o;
			2: return cal_busy_o;
			default: return mod_in_sel_o == 2'(k - 4);
		endcase
	endfunction
	task automatic wt(input int k, input logic v, input int lim);
		waited = 0;
		while (probe(k) !== v) begin
			if (waited == lim) begin
				n_errors++;
				$display("unexpected wait %0d: expected %b seen %b", k, v, probe(k));
				results();
			end
			cyc(1);
			waited++;
		end
	endtask
	task automatic next_word();
		wt(1, 1'b1, 200);
		wt(1, 1'b0, 200);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{reset_pin_i, sync_i, cal_i, bipolar_i} = 4'h0;
		{filt1_ovf_i, filt1_ovf_neg_i, mod_unstable_i, mod_unstable_neg_i} = 4'h0;
		rst_b_i = 1'b0;
		host_en = 1'b1;
		ana = 18'sh01234;
		cyc(2);
		chk("reset data", WORD_RST, data_o);
		chk("reset ready_n", 16'h0001, 16'(word_ready_n_o));
		rst_b_i = 1'b1;
		wt(0, 1'b1, 9000);
		chk("power-up settle", 16'h0001, 16'(waited > 8150));
		next_word();
		chk("raw word", 16'h1234, data_o);
		host_en = 1'b0;
		cyc(1);
		chk("released bus", 16'h0001, 16'(data_oe_n_o));
		host_en = 1'b1;
		$display("test power-up finished");
		for (int i = 0; i < 7; i++) begin
			ana = tv_in[i];
			{filt1_ovf_i, filt1_ovf_neg_i, bipolar_i} = tv_ctl[i][2:0];
			// Overflow ends before the decision edge so it does not spill into the next period
			wt(1, 1'b1, 200);
			filt1_ovf_i = 1'b0;
			wt(1, 1'b0, 200);
			chk("clipped word", tv_out[i], data_o);
			cyc(2);
			chk("valid", 16'(tv_ctl[i][3]), 16'(data_valid_flag_o));
		end
		chk("host word", 16'hffff, host_word);
		$display("test overflow finished");
		bipolar_i = 1'b1;
		ana = 18'sh00042;
		for (int k = 0; k < 2; k++) begin
			mod_unstable_i = (k == 0);
			sync_i = (k == 1);
			cyc(1);
			chk("filter reset", 16'h0001, 16'(filter_reset_o));
			chk("modulator reset", 16'(k == 0), 16'(mod_reset_o));
			sync_i = 1'b0;
			cyc(2);
			chk("valid dropped", 16'h0000, 16'(data_valid_flag_o));
			if (k == 0) chk("unstable clip", 16'h7fff, data_o);
			mod_unstable_i = 1'b0;
			wt(0, 1'b1, 9000);
			chk("settle", 16'h0001, 16'(waited > 8150));
			next_word();
			chk("word after settle", 16'h0042, data_o);
		end
		$display("test restart finished");
		bipolar_i = 1'b0;
		ana = 18'sh01100;
		pulses = 0;
		cal_i = 1'b1;
		wt(2, 1'b1, 3);
		wt(5, 1'b1, 70);
		chk("cal valid", 16'h0000, 16'(data_valid_flag_o));
		chk("cal ready_n", 16'h0001, 16'(word_ready_n_o));
		wt(6, 1'b1, 9000);
		cal_i = 1'b0;
		cyc(1);
		chk("offset pulses", 16'h0001, 16'(pulses));
		wt(2, 1'b0, 9000);
		chk("gain pulses", 16'h0002, 16'(pulses));
		chk("pins selected", 16'h0000, 16'(mod_in_sel_o));
		wt(0, 1'b1, 9000);
		chk("cal settle", 16'h0001, 16'(waited > 8150));
		next_word();
		chk("corrected word", 16'h3000, data_o);
		$display("test unipolar calibration finished");
		reset_pin_i = 1'b1;
		cyc(2);
		chk("reset pin modulator", 16'h0001, 16'(mod_reset_o));
		reset_pin_i = 1'b0;
		wt(0, 1'b1, 9000);
		next_word();
		chk("cleared correction", 16'h1100, data_o);
		$display("test reset input finished");
		bipolar_i = 1'b1;
		pulses = 0;
		cal_i = 1'b1;
		wt(2, 1'b1, 3);
		cal_i = 1'b0;
		wt(7, 1'b1, 20000);
		cyc(1);
		chk("half reference", 16'h0001, 16'(mod_half_ref_o));
		chk("bipolar pulses", 16'h0002, 16'(pulses));
		sync_i = 1'b1;
		cyc(1);
		chk("aborted", 16'h0000, 16'(cal_busy_o));
		sync_i = 1'b0;
		wt(0, 1'b1, 9000);
		next_word();
		chk("word after abort", 16'h1100, data_o);
		$display("test bipolar abort finished");
		results();
	end
endmodule // tb_avc_seq
bind avc_seq avc_seq_props i_props (.clk_i, .rst_b_i, .reset_pin_i, .sync_i, .cal_i,
	.mod_unstable_i, .cs_n_i, .rd_n_i, .data_oe_n_o, .word_ready_n_o, .data_valid_flag_o,
	.mod_reset_o, .filter_reset_o, .cal_busy_o);
